// File: src/basic_mode_control.sv
// basic mode control register of one transceiver port, with access-type helpers
// assumes a management front end gives a one-cycle read/write strobe on core_clk_in;
// auto-negotiation engine acknowledges a restart with an_started_in (same clock)
// clk_en_in low freezes every register, including the reset sequencer
// straps and the power-down pin are asynchronous and pass two flops here
// reserved bits and unmapped addresses never change state
module basic_mode_control
   import bmc_pkg::*;
#(
   parameter int SRST_LEN = SRST_CYCLES
) (
   input  wire logic        core_clk_in,          // device clock
   input  wire logic        rst_in,               // async reset, active high
   input  wire logic        clk_en_in,            // freezes all state when low
   input  wire logic        wr_in,                // management write strobe
   input  wire logic        rd_in,                // management read strobe
   input  wire logic [4:0]  addr_in,              // register address
   input  wire logic [15:0] wdata_in,             // write data
   output logic      [15:0] rdata_out,            // read data
   input  wire logic        strap_speed_in,       // speed strap pin
   input  wire logic        strap_duplex_in,      // duplex strap pin
   input  wire logic        strap_an_en_in,       // auto-neg enable strap pin
   input  wire logic        power_down_input_pin_n_in, // power-down pin, active low
   input  wire logic        an_started_in,        // negotiation engine began
   input  wire logic        tx_en_in,             // MII transmit enable
   output logic             soft_reset_out,       // port held in software reset
   output logic             loopback_out,         // route tx into rx
   output logic             speed_100_out,        // effective forced speed
   output logic             full_duplex_out,      // effective forced duplex
   output logic             an_enable_out,        // auto-negotiation enabled
   output logic             an_restart_out,       // one-cycle restart pulse
   output logic             power_down_out,       // port powered down
   output logic             isolate_out,          // port isolated from MII
   output logic             col_out               // collision in test mode
);
   // elaboration guard: the reset down-counter is 16 bits wide
   if (SRST_LEN < 1 || SRST_LEN > 65536) begin : g_bad_srst_len
      $error("SRST_LEN must be 1 to 65536");
   end

   // pin inputs pass two flops; stage one is read only by stage two
   logic [3:0] pin_raw, pin_s1_reg, pin_s2_reg;
   assign pin_raw = {~power_down_input_pin_n_in, strap_an_en_in, strap_duplex_in, strap_speed_in};
   // one synchroniser per pin; each is an independent level, so no bus coherency is needed
   for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge core_clk_in or posedge rst_in) begin
         if (rst_in) begin
            pin_s1_reg[g] <= 1'b0;
            pin_s2_reg[g] <= 1'b0;
         end else if (clk_en_in) begin
            pin_s1_reg[g] <= pin_raw[g];
            pin_s2_reg[g] <= pin_s1_reg[g];
         end
      end
   end
   logic pin_pd, strap_speed, strap_duplex, strap_an;
   assign {pin_pd, strap_an, strap_duplex, strap_speed} = pin_s2_reg;

   // address decode shared by the read and write paths
   function automatic logic hits_bmc(input logic [4:0] a);
      return a == BMC_OFFSET;
   endfunction
   logic sel_wr, sel_rd;
   assign sel_wr = wr_in && hits_bmc(addr_in);
   assign sel_rd = rd_in && hits_bmc(addr_in);

   // software reset sequencer; straps are caught clocked, never by the async reset
   srst_state_e srst_reg;
   logic [15:0] srst_cnt_reg;
   logic [2:0]  boot_reg;      // reload stays on until the strap synchronisers hold pin levels
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         srst_reg     <= SR_IDLE;
         srst_cnt_reg <= 16'h0000;
      end else if (clk_en_in) begin
         unique case (srst_reg)
            SR_IDLE: if (sel_wr && wdata_in[BIT_RESET]) begin
               srst_reg     <= SR_BUSY;
               srst_cnt_reg <= 16'(SRST_LEN - 1);
            end
            SR_BUSY: if (srst_cnt_reg == 16'h0000) srst_reg <= SR_DONE;
               else srst_cnt_reg <= srst_cnt_reg - 16'h0001;
            SR_DONE: srst_reg <= SR_IDLE; // bit clears once reset ends
         endcase
      end
   end
   // reload is held three cycles after release: the straps reach stage two only
   // at the second edge, so a single-cycle load would catch the reset zeros
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) boot_reg <= 3'b111;
      else if (clk_en_in) boot_reg <= {boot_reg[1:0], 1'b0};
   end
   logic reload;
   assign reload = boot_reg[2] || (srst_reg == SR_DONE);

   // control bits
   logic loop_reg, speed_reg, an_en_reg, pd_reg, iso_reg, dup_reg, colt_reg;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         {loop_reg, speed_reg, an_en_reg, pd_reg, iso_reg, dup_reg, colt_reg} <= 7'h00;
      end else if (clk_en_in) begin
         if (reload) begin
            // reset values: straps for speed, duplex, auto-neg; rest zero
            {loop_reg, pd_reg, iso_reg, colt_reg} <= 4'h0;
            speed_reg <= strap_speed;
            dup_reg   <= strap_duplex;
            an_en_reg <= strap_an;
         end else if (sel_wr && srst_reg == SR_IDLE) begin
            loop_reg  <= wdata_in[BIT_LOOPBACK];
            speed_reg <= wdata_in[BIT_SPEED];
            an_en_reg <= wdata_in[BIT_AN_EN];
            pd_reg    <= wdata_in[BIT_PWRDN];
            iso_reg   <= wdata_in[BIT_ISOLATE];
            dup_reg   <= wdata_in[BIT_DUPLEX];
            colt_reg  <= wdata_in[BIT_COL_TEST];
         end
      end
   end

   // restart: set on written one with auto-neg enabled, cleared when engine starts
   logic rst_an_reg, an_pulse_reg;
   logic an_req;
   assign an_req = sel_wr && wdata_in[BIT_AN_RESTART] && wdata_in[BIT_AN_EN]
                   && srst_reg == SR_IDLE && !reload;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rst_an_reg   <= 1'b0;
         an_pulse_reg <= 1'b0;
      end else if (clk_en_in) begin
         an_pulse_reg <= an_req;
         if (an_req) rst_an_reg <= 1'b1;                       // set wins over clear
         else if (an_started_in || reload) rst_an_reg <= 1'b0;
         // a written zero does not touch the bit or the engine
      end
   end

   // collision test: col follows tx_en within one clock, well inside bounds
   logic col_reg;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) col_reg <= 1'b0;
      else if (clk_en_in) col_reg <= colt_reg && tx_en_in;
   end

   // read data registered; reserved bits stay zero
   logic [15:0] rd_view;
   always_comb begin
      rd_view = 16'h0000;
      rd_view[BIT_RESET]      = (srst_reg != SR_IDLE);
      rd_view[BIT_LOOPBACK]   = loop_reg;
      rd_view[BIT_SPEED]      = speed_reg;
      rd_view[BIT_AN_EN]      = an_en_reg;
      rd_view[BIT_PWRDN]      = pd_reg || pin_pd;
      rd_view[BIT_ISOLATE]    = iso_reg;
      rd_view[BIT_AN_RESTART] = rst_an_reg;
      rd_view[BIT_DUPLEX]     = dup_reg;
      rd_view[BIT_COL_TEST]   = colt_reg;
      rd_view                 = rd_view & ~RSVD_MASK;
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) rdata_out <= 16'h0000;
      else if (clk_en_in && sel_rd) rdata_out <= rd_view;
   end
   // no clear-on-read or latched bits exist in this register
   // belong to the status registers built elsewhere

   // outputs to the port; forced speed and duplex ignored under auto-neg
   assign soft_reset_out  = (srst_reg != SR_IDLE);
   assign loopback_out    = loop_reg;                    // manager waits
   assign speed_100_out   = an_en_reg ? 1'b0 : speed_reg;
   assign full_duplex_out = an_en_reg ? 1'b0 : dup_reg;
   assign an_enable_out   = an_en_reg;
   assign an_restart_out  = an_pulse_reg;
   assign power_down_out  = pd_reg || pin_pd;
   assign isolate_out     = iso_reg;
   assign col_out         = col_reg;

   // multi-step behaviours are named so the properties read as steps
   sequence s_reset_write;
      sel_wr && wdata_in[BIT_RESET] && srst_reg == SR_IDLE;
   endsequence
   sequence s_restart_write;
      sel_wr && wdata_in[BIT_AN_RESTART] && wdata_in[BIT_AN_EN] && srst_reg == SR_IDLE && !reload && clk_en_in;
   endsequence
   sequence s_plain_write;
      sel_wr && srst_reg == SR_IDLE && !reload && clk_en_in;
   endsequence
   sequence s_last_busy;
      srst_reg == SR_BUSY && srst_cnt_reg == 16'h0000 && clk_en_in;
   endsequence

   // a written one starts the software reset
   a_reset_starts: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (s_reset_write and clk_en_in) |=> soft_reset_out)
      else $error("reset bit did not set");

   // the reset bit drops right after the reload cycle
   a_reset_ends: assert property (@(posedge core_clk_in) disable iff (rst_in)
      srst_reg == SR_DONE && clk_en_in |=> !soft_reset_out)
      else $error("reset bit did not clear");

   // the end of a software reset reloads the straps
   a_strap_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      srst_reg == SR_DONE && clk_en_in |=> an_en_reg == $past(strap_an) && dup_reg == $past(strap_duplex))
      else $error("straps not reloaded");

   // an asserted pin forces power-down and the bit reads one
   a_pd_or: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pin_pd |-> power_down_out && rd_view[BIT_PWRDN])
      else $error("power-down pin not honoured");

   // restart is dropped while negotiation is written off
   a_an_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in)
      sel_wr && !wdata_in[BIT_AN_EN] && clk_en_in |=> !an_restart_out)
      else $error("restart taken with auto-neg off");

   // a written zero leaves a pending restart alone
   a_an_zero_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      rst_an_reg && sel_wr && !wdata_in[BIT_AN_RESTART] && !an_started_in && !reload && clk_en_in
      |=> rst_an_reg)
      else $error("zero write cleared restart");

   // forced speed and duplex stay hidden under auto-negotiation
   a_forced_mode: assert property (@(posedge core_clk_in) disable iff (rst_in)
      an_en_reg |-> !speed_100_out && !full_duplex_out)
      else $error("forced mode leaked under auto-neg");

   // collision echo rises one clock after transmit enable
   a_col_test: assert property (@(posedge core_clk_in) disable iff (rst_in)
      colt_reg && tx_en_in && clk_en_in |=> col_out)
      else $error("collision test late");

   // reserved bits never read back as one
   a_rsvd_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (rdata_out & RSVD_MASK) == 16'h0000)
      else $error("reserved bits nonzero");

   // an accepted restart gives a pulse and sets the bit
   a_restart_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_restart_write |=> an_restart_out && rst_an_reg)
      else $error("restart not started");

   // the engine pulse follows only accepted written ones
   a_pulse_width: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in |=> an_restart_out == $past(an_req))
      else $error("restart pulse without request");

   // engine start clears the restart bit
   a_restart_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
      rst_an_reg && an_started_in && !an_req && clk_en_in |=> !rst_an_reg)
      else $error("restart bit did not clear");

   // loopback follows the written bit
   a_loop_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_plain_write |=> loopback_out == $past(wdata_in[BIT_LOOPBACK]))
      else $error("loopback not written");

   // isolate follows the written bit
   a_iso_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_plain_write |=> isolate_out == $past(wdata_in[BIT_ISOLATE]))
      else $error("isolate not written");

   // with negotiation off the forced bits reach the port
   a_forced_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !an_en_reg |-> speed_100_out == speed_reg && full_duplex_out == dup_reg)
      else $error("forced mode not applied");

   // the register bit alone powers the port down
   a_pd_bit: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pd_reg |-> power_down_out)
      else $error("power-down bit ignored");

   // with bit and pin both off the port runs
   a_pd_pin_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !pin_pd && !pd_reg |-> !power_down_out)
      else $error("power-down without cause");

   // the last busy count leads to the reload cycle
   a_reset_length: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_last_busy |=> srst_reg == SR_DONE)
      else $error("software reset overran");

   // a read during software reset shows the reset bit
   a_busy_reads_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
      sel_rd && soft_reset_out && clk_en_in |=> rdata_out[BIT_RESET])
      else $error("reset bit read zero while busy");

   // a written zero never starts a reset
   a_zero_no_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
      sel_wr && !wdata_in[BIT_RESET] && srst_reg == SR_IDLE && clk_en_in |=> !soft_reset_out)
      else $error("reset started by zero");

   // writes during a running reset leave the control bits alone
   a_busy_ignores: assert property (@(posedge core_clk_in) disable iff (rst_in)
      sel_wr && srst_reg == SR_BUSY && clk_en_in |=> $stable(loop_reg) && $stable(iso_reg) && $stable(pd_reg))
      else $error("write taken during reset");

   // collision echo drops one clock after transmit enable falls
   a_col_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !tx_en_in && clk_en_in |=> !col_out)
      else $error("collision echo stuck");

   // a low clock enable freezes the sequencer and the read port
   a_freeze_state: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !clk_en_in |=> $stable(srst_reg) && $stable(rdata_out) && $stable(rst_an_reg))
      else $error("state moved while frozen");

   // read data stands until the next read
   a_rdata_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !sel_rd && clk_en_in |=> $stable(rdata_out))
      else $error("read data changed without read");

   // the last boot cycle loads the synchronised straps
   a_strap_boot: assert property (@(posedge core_clk_in) disable iff (rst_in)
      boot_reg == 3'b100 && clk_en_in |=> an_en_reg == $past(strap_an) && speed_reg == $past(strap_speed))
      else $error("straps not loaded at start");

   // the reload cycle takes the speed strap too
   a_speed_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      srst_reg == SR_DONE && clk_en_in |=> speed_reg == $past(strap_speed))
      else $error("speed strap not reloaded");
endmodule

// File: src/bmc_pkg.sv
// package for the basic mode control register block
// assumes one 16-bit register at offset 0x00 of the management map
package bmc_pkg;
   localparam logic [4:0]  BMC_OFFSET     = 5'h00;
   localparam int          REG_W          = 16;
   localparam int          BIT_RESET      = 15;
   localparam int          BIT_LOOPBACK   = 14;
   localparam int          BIT_SPEED      = 13;
   localparam int          BIT_AN_EN      = 12;
   localparam int          BIT_PWRDN      = 11;
   localparam int          BIT_ISOLATE    = 10;
   localparam int          BIT_AN_RESTART = 9;
   localparam int          BIT_DUPLEX     = 8;
   localparam int          BIT_COL_TEST   = 7;
   localparam logic [15:0] RSVD_MASK      = 16'h007f;
   // software reset duration, in device clocks
   localparam int          SRST_CYCLES    = 16;
   // collision test bounds in bit times
   localparam int          COL_ON_BITS    = 512;
   localparam int          COL_OFF_BITS   = 4;
   typedef enum logic [1:0] {SR_IDLE, SR_BUSY, SR_DONE} srst_state_e;
endpackage

// File: sim/mgmt_model.sv
// management station model: write and read cycles on the one-cycle strobe interface
// assumes strobes are sampled at rising edges of core_clk_in and addr 0x00 is decoded
module mgmt_model #(
   parameter int DEAD_CYCLES = 10000
) (
   input  wire logic        core_clk_in, // device clock
   input  wire logic [15:0] rdata_in,    // read data from block
   output logic             wr_out,      // write strobe
   output logic             rd_out,      // read strobe
   output logic      [4:0]  addr_out,    // register address
   output logic      [15:0] wdata_out    // write data
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus shows inverted values so stale data never passes for live data
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 5'h1f;
      wdata_out = 16'hffff;
   end
   // one strobe cycle, request held until the edge that takes it
   task automatic cycle(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      wr_out <= w;
      rd_out <= !w;
      addr_out <= a;
      wdata_out <= d;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      cycle(1'b1, a, d);
      // receive path may stay dead after loopback is set, so wait it out
      if (d[14]) repeat (DEAD_CYCLES) @(posedge core_clk_in);
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      cycle(1'b0, a, 16'h0000);
      @(posedge core_clk_in);
      d = rdata_in;
   endtask
endmodule

// File: sim/basic_mode_control_tb_top.sv
// testbench top: drives basic_mode_control through the management model
// assumes one clock at 20 MHz and straps driven directly by the bench
module basic_mode_control_tb_top;
   import bmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, wr, rd, s_spd = 1'b1, s_dup = 1'b0, s_an = 1'b0;
   logic pdn_n = 1'b1, an_go = 1'b0, tx_en = 1'b0, clk_en = 1'b1;
   logic o_sr, o_lb, o_spd, o_fd, o_an, o_rs, o_pd, o_iso, o_col;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   int mismatches = 0, total_checks = 0, pulses = 0;
   // rows: written word, expected read, expected {loop, speed, duplex, an, pdn, isolate}
   logic [15:0] row_w [8] = '{16'h4000, 16'h2100, 16'h0000, 16'h3100, 16'h0800, 16'h0400, 16'h007f, 16'h0080};
   logic [15:0] row_r [8] = '{16'h4000, 16'h2100, 16'h0000, 16'h3100, 16'h0800, 16'h0400, 16'h0000, 16'h0080};
   logic [5:0]  row_o [8] = '{6'h20, 6'h18, 6'h00, 6'h04, 6'h02, 6'h01, 6'h00, 6'h00};
   // short software reset keeps the run brief
   basic_mode_control #(.SRST_LEN(8)) dut (.core_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en),
      .wr_in(wr), .rd_in(rd), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
      .strap_speed_in(s_spd), .strap_duplex_in(s_dup), .strap_an_en_in(s_an),
      .power_down_input_pin_n_in(pdn_n), .an_started_in(an_go), .tx_en_in(tx_en),
      .soft_reset_out(o_sr), .loopback_out(o_lb), .speed_100_out(o_spd), .full_duplex_out(o_fd),
      .an_enable_out(o_an), .an_restart_out(o_rs), .power_down_out(o_pd), .isolate_out(o_iso),
      .col_out(o_col));
   mgmt_model u_mgmt (.core_clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));
   // free-running device clock, 50 ns period
   initial begin
      forever #25 clk = ~clk;
   end
   // restart pulses are counted so missing or extra ones both show
   always @(posedge clk) begin
      if (o_rs === 1'b1) pulses++;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog: the dead-time wait dominates, well under this span
   initial begin
      #2000000;
      mismatches++;
      give_verdict();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h2000);
      chk(16'({o_lb, o_spd, o_fd, o_an, o_pd, o_iso}), 16'h0010);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         u_mgmt.wr_reg(5'h00, row_w[i]);
         u_mgmt.rd_reg(5'h00, d);
         chk(d, row_r[i]);
         chk(16'({o_lb, o_spd, o_fd, o_an, o_pd, o_iso}), 16'(row_o[i]));
         $display("row %0d done", i);
      end
      // collision test is on from the last row; echo follows transmit enable
      tx_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk(16'(o_col), 16'h0001);
      tx_en <= 1'b0;
      repeat (3) @(posedge clk);
      chk(16'(o_col), 16'h0000);
      u_mgmt.wr_reg(5'h03, 16'h0400);
      u_mgmt.rd_reg(5'h05, d);
      chk(d, 16'h0080);
      $display("collision and unmapped test done");
      // restart is ignored while negotiation is disabled, then honoured
      u_mgmt.wr_reg(5'h00, 16'h0200);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h0000);
      chk(16'(pulses), 16'h0000);
      u_mgmt.wr_reg(5'h00, 16'h1200);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h1200);
      chk(16'(pulses), 16'h0001);
      u_mgmt.wr_reg(5'h00, 16'h1000);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h1200);
      chk(16'(pulses), 16'h0001);
      an_go <= 1'b1;
      @(posedge clk);
      an_go <= 1'b0;
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h1000);
      $display("restart test done");
      // power-down pin ORs into the register bit
      pdn_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(o_pd), 16'h0001);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h1800);
      pdn_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(16'(o_pd), 16'h0000);
      $display("power-down pin test done");
      // frozen clock enable: a write must leave no trace
      clk_en <= 1'b0;
      u_mgmt.wr_reg(5'h00, 16'h0400);
      clk_en <= 1'b1;
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h1000);
      chk(16'(o_iso), 16'h0000);
      $display("clock enable test done");
      // software reset with a changed strap: bit reads one, then straps reload
      s_dup <= 1'b1;
      u_mgmt.wr_reg(5'h00, 16'h8400);
      @(posedge clk);
      chk(16'(o_sr), 16'h0001);
      u_mgmt.rd_reg(5'h00, d);
      chk(16'(d[15]), 16'h0001);
      for (int k = 0; k < 40 && o_sr !== 1'b0; k++) @(posedge clk);
      u_mgmt.rd_reg(5'h00, d);
      chk(d, 16'h2100);
      chk(16'({o_fd, o_iso}), 16'h0002);
      $display("software reset test done");
      give_verdict();
   end
endmodule
